// >>> ssp_config_port.sv
// Slave serial configuration port: serial link logic on the master's clock,
// command engine on the system clock. Assumes an external master driving
// the serial clock only while select is low, and a configuration engine on clk_in.
`include "ssp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ssp_config_port
	import ssp_pkg::*;
(
	// System clock and reset.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Serial link, bit n of each vector is data line n.
	input wire logic sclk_in,
	input wire logic port_select_n_in,
	input wire logic [3:0] data_line_in,
	output logic [3:0] data_line_out,
	output logic [3:0] data_line_oe_out,
	// Device state.
	input wire logic program_pin_n_in,
	input wire logic user_mode_in,
	input wire ssp_persist_t persist_in,
	input wire logic refresh_in,
	// Command and data toward the configuration logic.
	output ssp_cmd_t cmd_out,
	output logic cmd_valid_out,
	output logic [7:0] wr_data_out,
	output logic wr_valid_out,
	output logic cmd_done_out,
	output logic cmd_abort_out,
	output logic cmd_refused_out,
	// Read data from the configuration logic, taken one cycle after the request.
	output logic rd_req_out,
	input wire logic [7:0] rd_data_in,
	// Port status.
	output logic port_open_out,
	output logic transparent_out,
	output ssp_width_t width_out
);

	// Header length in bytes for an opcode.
	function automatic logic [2:0] hdr_len(input logic [7:0] op);
		hdr_len = op[`SSP_OP_ARG_BIT] ? `SSP_HDR_ARG : `SSP_HDR_NOARG;
	endfunction

	// Read-type decode of an opcode.
	function automatic logic is_rd(input logic [7:0] op);
		is_rd = op[`SSP_OP_RD_BIT];
	endfunction

	// Saturating byte count increment.
	function automatic logic [2:0] cnt_inc(input logic [2:0] c);
		cnt_inc = (c == `SSP_CNT_MAX) ? c : c + 3'h1;
	endfunction

	// ---------------- Link side, serial clock ----------------

	logic [2:0] bib_reg;
	logic [2:0] bib_next;
	logic [2:0] bidx_reg;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic [7:0] op_reg;
	logic [7:0] op_now;
	logic [7:0] rx_byte_reg;
	logic rx_tgl_reg;
	logic rd_tgl_reg;
	logic part_reg;
	logic byte_end;
	logic [7:0] cur_reg;
	logic [7:0] tx_src;
	logic [7:0] tx_shl;
	logic [3:0] tx_bits;
	logic [3:0] tx_mask;
	logic rd_phase;
	logic [7:0] rd_hold_reg;
	ssp_width_t width_reg;
	logic open_reg;

	// Input shift per width; line 0 is the only input in serial mode.
	always_comb begin
		case (width_reg)
			SSP_X2: begin
				sh_next = {sh_reg[5:0], data_line_in[1:0]};
				bib_next = bib_reg + `SSP_STEP_X2;
			end
			SSP_X4: begin
				sh_next = {sh_reg[3:0], data_line_in[3:0]};
				bib_next = bib_reg + `SSP_STEP_X4;
			end
			default: begin
				sh_next = {sh_reg[6:0], data_line_in[0]};
				bib_next = bib_reg + `SSP_STEP_X1;
			end
		endcase
		byte_end = (bib_next == 3'h0);
		op_now = (bidx_reg == 3'h0) ? sh_next : op_reg;
	end

	// Frame state is held clear while select is high, so every frame starts
	// from a fresh opcode; frames change width_reg and open_reg only while select is
	// high, and the master must keep select high long enough for that; refresh_in
	// and the program pin reset width_reg, and user_mode_in and the program pin change open_reg, at any time.
	always_ff @(posedge sclk_in or posedge port_select_n_in) begin
		if (port_select_n_in) begin
			bib_reg <= 3'h0;
			bidx_reg <= 3'h0;
			sh_reg <= 8'h00;
			op_reg <= 8'h00;
		end else begin
			sh_reg <= sh_next;
			bib_reg <= bib_next;
			if (byte_end) begin
				bidx_reg <= cnt_inc(bidx_reg);
				if (bidx_reg == 3'h0) begin
					op_reg <= sh_next;
				end
			end
		end
	end

	// Events toward the system side travel as toggles, which survive the
	// select reset; the system reset is the only thing that clears them.
	always_ff @(posedge sclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_byte_reg <= 8'h00;
			rx_tgl_reg <= 1'b0;
			rd_tgl_reg <= 1'b0;
			part_reg <= 1'b0;
		end else begin
			part_reg <= (bib_next != 3'h0);
			if (byte_end) begin
				rx_byte_reg <= sh_next;
				rx_tgl_reg <= ~rx_tgl_reg;
				if (open_reg && is_rd(op_now) && cnt_inc(bidx_reg) >= hdr_len(op_now)) begin
					rd_tgl_reg <= ~rd_tgl_reg;
				end
			end
		end
	end

	// Output chunk selection; a new byte is taken at each byte boundary.
	always_comb begin
		rd_phase = open_reg && is_rd(op_reg) && bidx_reg != 3'h0 && bidx_reg >= hdr_len(op_reg);
		tx_src = (bib_reg == 3'h0) ? rd_hold_reg : cur_reg;
		tx_shl = tx_src << bib_reg;
		case (width_reg)
			SSP_X2: begin
				tx_bits = {2'b00, tx_shl[7:6]};
				tx_mask = `SSP_MASK_X2;
			end
			SSP_X4: begin
				tx_bits = tx_shl[7:4];
				tx_mask = `SSP_MASK_X4;
			end
			default: begin
				tx_bits = {2'b00, tx_shl[7], 1'b0};
				tx_mask = `SSP_MASK_X1;
			end
		endcase
	end

	// Drivers turn off at once when select rises, without waiting for a clock.
	always_ff @(negedge sclk_in or posedge port_select_n_in) begin
		if (port_select_n_in) begin
			cur_reg <= 8'h00;
			data_line_out <= 4'h0;
			data_line_oe_out <= 4'h0;
		end else begin
			if (bib_reg == 3'h0) begin
				cur_reg <= rd_hold_reg;
			end
			data_line_out <= tx_bits;
			data_line_oe_out <= rd_phase ? tx_mask : 4'h0;
		end
	end

	// ---------------- System side, clk_in ----------------

	logic [4:0] sync_in;
	logic [4:0] s1_reg;
	logic [4:0] s2_reg;
	logic [4:0] s3_reg;
	logic sel_s4_reg;
	logic rx_ev;
	logic rd_ev;
	logic pg_fall;
	logic sel_fall;
	logic sel_rise;
	logic part_s;
	ssp_state_t st_reg;
	logic [2:0] cnt_reg;
	logic [31:0] last_reg;

	assign sync_in = {part_reg, port_select_n_in, program_pin_n_in, rd_tgl_reg, rx_tgl_reg};

	// Two-stage synchronisers plus one stage for edge detection.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1_reg <= `SSP_SYNC_RST;
			s2_reg <= `SSP_SYNC_RST;
			s3_reg <= `SSP_SYNC_RST;
			sel_s4_reg <= 1'b1;
		end else begin
			s1_reg <= sync_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sel_s4_reg <= s3_reg[3];
		end
	end

	// Select rise is seen one cycle late so the final byte is counted first.
	always_comb begin
		rx_ev = s2_reg[0] ^ s3_reg[0];
		rd_ev = s2_reg[1] ^ s3_reg[1];
		pg_fall = !s2_reg[2] && s3_reg[2];
		sel_fall = !s2_reg[3] && s3_reg[3];
		sel_rise = s3_reg[3] && !sel_s4_reg;
		part_s = s3_reg[4];
	end

	// Command engine: gathers header bytes, issues, streams write data.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_reg <= SSP_IDLE;
			cnt_reg <= 3'h0;
			last_reg <= 32'h0000_0000;
			cmd_out <= '0;
			cmd_valid_out <= 1'b0;
			wr_data_out <= 8'h00;
			wr_valid_out <= 1'b0;
			cmd_done_out <= 1'b0;
			cmd_abort_out <= 1'b0;
			cmd_refused_out <= 1'b0;
		end else begin
			cmd_valid_out <= 1'b0;
			wr_valid_out <= 1'b0;
			cmd_done_out <= 1'b0;
			cmd_abort_out <= 1'b0;
			cmd_refused_out <= 1'b0;
			if (sel_fall) begin
				st_reg <= SSP_IDLE;
				cnt_reg <= 3'h0;
			end else if (rx_ev) begin
				last_reg <= {last_reg[23:0], rx_byte_reg};
				cnt_reg <= cnt_inc(cnt_reg);
				case (st_reg)
					SSP_IDLE, SSP_HDR: begin
						if (st_reg == SSP_IDLE) begin
							cmd_out.opcode <= rx_byte_reg;
							cmd_out.operand <= 24'h00_0000;
						end else begin
							cmd_out.operand <= {cmd_out.operand[15:0], rx_byte_reg};
						end
						if (cnt_inc(cnt_reg) == hdr_len(st_reg == SSP_IDLE ? rx_byte_reg : cmd_out.opcode)) begin
							if (!open_reg) begin
								st_reg <= SSP_DROP;
							end else if (transparent_out && !is_rd(st_reg == SSP_IDLE ? rx_byte_reg : cmd_out.opcode)) begin
								cmd_refused_out <= 1'b1;
								st_reg <= SSP_DROP;
							end else begin
								cmd_valid_out <= 1'b1;
								st_reg <= SSP_RUN;
							end
						end else begin
							st_reg <= SSP_HDR;
						end
					end
					SSP_RUN: begin
						if (!is_rd(cmd_out.opcode)) begin
							wr_data_out <= rx_byte_reg;
							wr_valid_out <= 1'b1;
						end
					end
					default: begin
						st_reg <= st_reg;
					end
				endcase
			end else if (sel_rise) begin
				if (st_reg == SSP_HDR || (st_reg == SSP_RUN && part_s)) begin
					cmd_abort_out <= 1'b1;
				end else if (st_reg == SSP_RUN) begin
					cmd_done_out <= 1'b1;
				end
				st_reg <= SSP_IDLE;
			end
		end
	end

	// Read bytes are fetched one step ahead; the first byte after the header
	// goes out as zero because the fetch cannot beat half a serial clock.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_req_out <= 1'b0;
			rd_hold_reg <= 8'h00;
		end else begin
			rd_req_out <= rd_ev;
			if (sel_fall) begin
				rd_hold_reg <= 8'h00;
			end else if (rd_req_out) begin
				rd_hold_reg <= rd_data_in;
			end
		end
	end

	// Activation, persistence and width.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			open_reg <= 1'b0;
			port_open_out <= 1'b0;
			transparent_out <= 1'b0;
			width_reg <= SSP_X1;
		end else begin
			if (user_mode_in) begin
				open_reg <= (persist_in != SSP_P_OFF);
				transparent_out <= (persist_in != SSP_P_OFF);
			end else if (pg_fall) begin
				open_reg <= 1'b0;
				transparent_out <= 1'b0;
			end else if (sel_rise && !part_s && cnt_reg >= `SSP_KEY_MIN_BYTES && last_reg == `SSP_ACT_KEY) begin
				open_reg <= 1'b1;
				transparent_out <= 1'b0;
			end else begin
				transparent_out <= 1'b0;
			end
			port_open_out <= open_reg;
			if (pg_fall || refresh_in) begin
				width_reg <= SSP_X1;
			end else if (sel_rise && !part_s && width_reg == SSP_X1 && cnt_reg == `SSP_WORD_BYTES) begin
				if (last_reg == `SSP_DUAL_EN) begin
					width_reg <= SSP_X2;
				end else if (last_reg == `SSP_QUAD_EN) begin
					width_reg <= SSP_X4;
				end
			end
		end
	end

	assign width_out = width_reg;

endmodule

`default_nettype wire

// >>> ssp_params.svh
// Constants for the slave serial configuration port: opcode fields, special
// words, byte counts and reset values. Assumes inclusion by ssp_config_port.sv.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Opcode bit that marks a read-type command.
`define SSP_OP_RD_BIT 7
// Opcode bit that marks a command carrying a 24-bit operand.
`define SSP_OP_ARG_BIT 6

// Header length in bytes with and without an operand.
`define SSP_HDR_ARG 3'h4
`define SSP_HDR_NOARG 3'h1
// Byte count saturates here.
`define SSP_CNT_MAX 3'h7
// A width word frame is exactly four bytes long.
`define SSP_WORD_BYTES 3'h4
// Activation needs a dummy byte plus the four key bytes.
`define SSP_KEY_MIN_BYTES 3'h5

// Special 32-bit words.
`define SSP_ACT_KEY 32'ha4c6f48a
`define SSP_DUAL_EN 32'hd9b33eb3
`define SSP_QUAD_EN 32'hd9b33ebd

// Bit steps per serial clock edge for each width.
`define SSP_STEP_X1 3'h1
`define SSP_STEP_X2 3'h2
`define SSP_STEP_X4 3'h4

// Lines driven for each width, bit n is data line n.
`define SSP_MASK_X1 4'h2
`define SSP_MASK_X2 4'h3
`define SSP_MASK_X4 4'hf

// Synchroniser reset: bit 4 partial, 3 select, 2 program pin, 1 read, 0 receive.
`define SSP_SYNC_RST 5'h0c

`endif

// >>> ssp_pkg.sv
// Types shared by the slave serial configuration port.
// Assumes ssp_params.svh supplies the numeric constants.
package ssp_pkg;

	// Data width of the port.
	typedef enum logic [1:0] {SSP_X1, SSP_X2, SSP_X4} ssp_width_t;

	// Persistence setting carried by the loaded configuration.
	typedef enum logic [1:0] {SSP_P_OFF, SSP_P_SERIAL, SSP_P_DUAL, SSP_P_QUAD} ssp_persist_t;

	// Command engine states.
	typedef enum logic [1:0] {SSP_IDLE, SSP_HDR, SSP_RUN, SSP_DROP} ssp_state_t;

	// Decoded command handed to the configuration logic.
	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] operand;
	} ssp_cmd_t;

endpackage

// >>> ssp_config_port_monitor.sv
// Assertions on the configuration port's pins and result pulses.
// Assumes it is bound into ssp_config_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ssp_mon
	import ssp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Inputs watched.
	input wire logic port_select_n_in,
	input wire logic program_pin_n_in,
	input wire logic refresh_in,
	// Outputs watched.
	input wire logic [3:0] data_line_oe_out,
	input wire ssp_cmd_t cmd_out,
	input wire logic cmd_valid_out,
	input wire logic cmd_done_out,
	input wire logic cmd_abort_out,
	input wire logic cmd_refused_out,
	input wire logic port_open_out,
	input wire logic transparent_out,
	input wire ssp_width_t width_out
);
	// Everything samples on the system clock, so link timing is checked only coarsely.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_desel_tristate: assert property (port_select_n_in |-> data_line_oe_out == 4'h0)
		else $error("driver on while deselected");
	a_x1_one_line: assert property (width_out == SSP_X1 |-> (data_line_oe_out & 4'hd) == 4'h0)
		else $error("serial width drives a wrong line");
	a_transp_reads: assert property (transparent_out && cmd_valid_out |-> cmd_out.opcode[7])
		else $error("write accepted in transparent mode");
	a_refuse_transp: assert property (cmd_refused_out |-> transparent_out && !cmd_valid_out)
		else $error("refusal outside transparent mode");
	a_end_after_rise: assert property (cmd_done_out || cmd_abort_out |-> port_select_n_in && $past(port_select_n_in, 2))
		else $error("command ended without select high");
	a_closed_silent: assert property (!port_open_out && !transparent_out |-> !cmd_valid_out)
		else $error("command accepted on a closed port");
	a_refresh_x1: assert property (refresh_in |-> ##[1:3] width_out == SSP_X1)
		else $error("refresh left a wide width");
	a_widen_from_x1: assert property (width_out != SSP_X1 && $changed(width_out) |-> $past(width_out) == SSP_X1)
		else $error("width widened from a wide mode");
	a_prog_closes: assert property ($fell(program_pin_n_in) |-> ##[1:8] !port_open_out && width_out == SSP_X1)
		else $error("program pin did not close the port");
	// Main scenarios reached.
	c_done: cover property (cmd_done_out);
	c_refused: cover property (cmd_refused_out);
	c_quad: cover property (width_out == SSP_X4);
endmodule
bind ssp_config_port ssp_mon mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .port_select_n_in(port_select_n_in),
	.program_pin_n_in(program_pin_n_in), .refresh_in(refresh_in), .data_line_oe_out(data_line_oe_out),
	.cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out), .cmd_done_out(cmd_done_out), .cmd_abort_out(cmd_abort_out),
	.cmd_refused_out(cmd_refused_out), .port_open_out(port_open_out), .transparent_out(transparent_out),
	.width_out(width_out));
`default_nettype wire

// >>> ssp_master.sv
// Serial master model that sends whole-byte frames to the configuration port.
// Assumes the bench resolves line levels from the port's enables.
`timescale 1ns/1ps
`default_nettype none
module ssp_master (
	// Resolved data line levels.
	input wire logic [3:0] dl_in,
	// Clock, select and data driven by the master.
	output logic sclk_out,
	output logic sel_n_out,
	output logic [3:0] drv_out
);
	logic [7:0] rx[$];

	// Idle: clock stands low, deselected.
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		drv_out = 4'hf;
	end

	// One frame; the gap stretches bytes so a slow system clock keeps up.
	task automatic frame(input logic [7:0] b[$], input int w, input int gap);
		logic [7:0] r;
		logic [3:0] mk;
		mk = 4'((1 << w) - 1);
		r = 8'h00;
		rx.delete();
		sel_n_out = 1'b0;
		#23;
		foreach (b[i]) begin
			for (int k = 8 - w; k >= 0; k -= w) begin
				drv_out = 4'(b[i] >> k) & mk;
				#6 sclk_out = 1'b1;
				r = (r << w) | 8'(w == 1 ? dl_in[1] : dl_in & mk);
				#6 sclk_out = 1'b0;
			end
			rx.push_back(r);
			#(gap);
		end
		sel_n_out = 1'b1;
		drv_out = ~drv_out;
		#100;
	endtask
endmodule
`default_nettype wire

// >>> tb_slave_spi_config_port.sv
// Bench: a master model drives the link, the bench drives the config side.
// Assumes the design, master model and monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_slave_spi_config_port;
	import ssp_pkg::*;
	logic clk_in, sys_rst_in, sclk, sel_n, prog_n, user, refresh, cv, wv, done, abort, refused, rd_req, open, transp;
	logic [3:0] drv, dout, doe, dl;
	logic [7:0] wd, rd_data, rv;
	logic [35:0] got;
	logic [35:0] q[$];
	logic [7:0] rdq[$];
	ssp_persist_t persist;
	ssp_cmd_t cmd;
	ssp_width_t width;
	int errors, n_checks, seed, cyc;

	ssp_config_port dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .port_select_n_in(sel_n),
		.data_line_in(dl), .data_line_out(dout), .data_line_oe_out(doe), .program_pin_n_in(prog_n),
		.user_mode_in(user), .persist_in(persist), .refresh_in(refresh), .cmd_out(cmd), .cmd_valid_out(cv),
		.wr_data_out(wd), .wr_valid_out(wv), .cmd_done_out(done), .cmd_abort_out(abort),
		.cmd_refused_out(refused), .rd_req_out(rd_req), .rd_data_in(rd_data), .port_open_out(open),
		.transparent_out(transp), .width_out(width));
	ssp_master m (.dl_in(dl), .sclk_out(sclk), .sel_n_out(sel_n), .drv_out(drv));
	// Each line carries whichever party enables it.
	assign dl = (doe & dout) | (~doe & drv);

	// System clock.
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task chk(input logic [35:0] a, input logic [35:0] e, input string s);
		n_checks++;
		if (a !== e) begin
			errors++;
			$display("BAD %0t %s %h %h", $time, s, a, e);
		end
	endtask

	task results;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task st(input logic [35:0] e, input string s);
		repeat (12) @(posedge clk_in);
		chk(36'({width, open, transp}), e, s);
		$display("test %s done", s);
	endtask

	// A command frame; its results are noted before it is sent.
	task automatic cmdf(input logic [7:0] op, input int nd, input int w, input logic [3:0] k, input int gap);
		logic [7:0] b[$];
		logic [23:0] a;
		a = 24'($random(seed));
		b = {op, a[23:16], a[15:8], a[7:0]};
		if (k == 4'h3) q.push_back({4'h1, op, a});
		if (k == 4'h5) q.push_back({4'h5, 32'h0});
		repeat (nd) begin
			b.push_back(8'($random(seed)));
			if (k == 4'h3 && !op[7]) q.push_back({4'h2, 24'h0, b[$]});
		end
		if (k == 4'h3) q.push_back({4'h3, 32'h0});
		rdq.delete();
		m.frame(b, w, gap);
		if (k == 4'h3 && op[7]) begin
			chk(36'(m.rx[4]), 36'h0, "rd0");
			chk(36'(m.rx[5]), 36'(rdq[0]), "rd1");
			if (nd > 2)
				chk(36'(m.rx[6]), 36'(rdq[1]), "rd2");
		end
		repeat (12) @(posedge clk_in);
		$display("test cmd %h done", op);
	endtask

	// A width word frame; its first byte also decodes as a read opcode with an
	// operand, so the engine issues it and reports it done at select rise.
	task automatic width_frame(input logic [31:0] v, input int w);
		q.push_back({4'h1, v});
		q.push_back({4'h3, 32'h0});
		m.frame({v[31:24], v[23:16], v[15:8], v[7:0]}, w, 40);
	endtask

	// Each result pulse takes the oldest noted expectation.
	always @(posedge clk_in) begin
		if (!sys_rst_in && (cv | wv | done | abort | refused)) begin
			got = {cv ? 4'h1 : wv ? 4'h2 : done ? 4'h3 : abort ? 4'h4 : 4'h5, cv ? cmd : wv ? {24'h0, wd} : 32'h0};
			if (q.size() == 0)
				chk(got, 36'h0, "extra");
			else
				chk(got, q.pop_front(), "result");
		end
	end

	// The design takes the byte standing at the edge that ends its request, so
	// that byte is noted and the next one is put up behind it.
	always @(posedge clk_in) begin
		if (rd_req) begin
			rdq.push_back(rd_data);
			rv = 8'($random(seed));
			rd_data <= rv;
		end
	end

	// A hang is cut short well past the expected run length.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end

	initial begin
		seed = 83658;
		errors = 0;
		n_checks = 0;
		cyc = 0;
		sys_rst_in = 1'b1;
		prog_n = 1'b1;
		user = 1'b0;
		refresh = 1'b0;
		rd_data = 8'($random(seed));
		persist = SSP_P_OFF;
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		st(36'h0, "reset");
		cmdf(8'h40, 1, 1, 4'h0, 40);
		m.frame({8'ha4, 8'hc6, 8'hf4, 8'h8a}, 1, 40);
		st(36'h0, "no dummy");
		m.frame({8'h5a, 8'ha4, 8'hc6, 8'hf4, 8'h8a}, 1, 40);
		st(36'h2, "key");
		cmdf(8'h40, 3, 1, 4'h3, 40);
		cmdf(8'hc0, 3, 1, 4'h3, 300);
		q.push_back({4'h4, 32'h0});
		m.frame({8'h40, 8'h12}, 1, 40);
		width_frame(32'hd9b33eb3, 1);
		st(36'h6, "dual");
		cmdf(8'h40, 2, 2, 4'h3, 40);
		cmdf(8'hc0, 2, 2, 4'h3, 40);
		width_frame(32'hd9b33ebd, 2);
		st(36'h6, "stay x2");
		@(posedge clk_in) refresh <= 1'b1;
		@(posedge clk_in) refresh <= 1'b0;
		st(36'h2, "refresh");
		width_frame(32'hd9b33ebd, 1);
		st(36'ha, "quad");
		cmdf(8'h40, 2, 4, 4'h3, 40);
		cmdf(8'hc0, 2, 4, 4'h3, 40);
		@(posedge clk_in) prog_n <= 1'b0;
		st(36'h0, "program pin");
		@(posedge clk_in) prog_n <= 1'b1;
		user <= 1'b1;
		st(36'h0, "released");
		persist <= SSP_P_SERIAL;
		repeat (12) @(posedge clk_in);
		chk(36'(transp), 36'h1, "transparent");
		cmdf(8'h40, 1, 1, 4'h5, 40);
		cmdf(8'hc0, 2, 1, 4'h3, 40);
		chk(36'(q.size()), 36'h0, "left");
		results();
	end
endmodule
`default_nettype wire
